/* src/ccs_pkg.sv */
// Purpose: shared constants for the control-state decoder
// Assumes: 4096-location array, 32-bit data bus, 6-bit low op code field
// Notes:   register images below are full 32-bit words, reserved bits zero
package ccs_pkg;

  // ==========
  // sizes
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned PAGE_W  = 4;
  localparam int unsigned OP_W    = 12;
  localparam int unsigned OPLO_W  = 6;

  // ==========
  // op code low six bits
  localparam logic [5:0] OP_POINTER_STEP_UP     = 6'h24;
  localparam logic [5:0] OP_POINTER_STEP_DOWN   = 6'h25;
  localparam logic [5:0] OP_PATH_BIT_SET_VALID  = 6'h28;
  localparam logic [5:0] OP_PATH_BIT_READ       = 6'h28;
  localparam logic [5:0] OP_PATH_BIT_SET_INVAL  = 6'h29;
  localparam logic [5:0] OP_PAGE_NUMBER_LOAD    = 6'h3C;
  localparam logic [5:0] OP_FULL_FLAG_CLEAR     = 6'h3D;
  localparam logic [5:0] OP_SOFT_RESET          = 6'h3F;
  localparam logic [5:0] OP_CONFIG_ACCESS       = 6'h30;
  localparam logic [5:0] OP_SELECT_ACCESS       = 6'h31;
  localparam logic [5:0] OP_INSTR_READ          = 6'h32;

  // ==========
  // configuration register fields
  localparam int unsigned CFG_MASKSRC_LO = 29;
  localparam int unsigned CFG_MODE_LO    = 26;
  localparam int unsigned CFG_LOWPRI_BIT = 25;
  localparam int unsigned CFG_PTDIS_BIT  = 24;
  localparam int unsigned CFG_PTMASK_LO  = 12;
  localparam int unsigned CFG_PTPAGE_LO  = 8;
  localparam int unsigned CFG_PAGE_LO    = 0;
  localparam logic [31:0] CFG_RESET      = 32'h0FFF_FF0F;
  localparam logic [31:0] CFG_WR_MASK    = 32'hEFFF_FF0F;

  localparam logic [1:0]  MODE_HARDWARE  = 2'h0;
  localparam logic [1:0]  MODE_SOFTWARE  = 2'h3;

  // ==========
  // device select register fields
  localparam int unsigned SEL_ENABLE_BIT = 8;
  localparam int unsigned SEL_VALUE_LO   = 0;
  localparam logic [31:0] SEL_RESET      = 32'h0000_010F;
  localparam logic [31:0] SEL_WR_MASK    = 32'h0000_010F;

  // ==========
  // status register fields
  localparam int unsigned STAT_FULL_BIT  = 28;
  localparam int unsigned STAT_ATYPE_LO  = 24;
  localparam int unsigned STAT_PAGE_LO   = 16;
  localparam logic [2:0]  STAT_MATCH_RST = 3'h7;
  localparam logic [31:0] STAT_RESET     = 32'hF30F_0FFF;

  typedef enum logic [1:0] {
    ATYPE_MATCH  = 2'b00,
    ATYPE_MEMORY = 2'b01,
    ATYPE_PATH   = 2'b10,
    ATYPE_RESET  = 2'b11
  } ccs_atype_e;

  localparam logic [ADDR_W-1:0] ADDR_PTR_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_ALL_ONES  = 12'hFFF;
  localparam logic [PAGE_W-1:0] PAGE_ALL_ONES  = 4'hF;
  localparam logic [OP_W-1:0]   INSTR_RESET    = 12'h000;

endpackage : ccs_pkg

/* src/ccs_sync2.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: bits are independent levels
// Notes:   first stage is read only by the second
module ccs_sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // level in and out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage1_q <= RESET_VAL;
      syncOut  <= RESET_VAL;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule : ccs_sync2

/* src/ccs_path_table.sv */
// Purpose: one-bit-per-location path table store
// Assumes: single port, write and registered read on the same address
// Notes:   deliberately has no reset; contents survive every reset
module ccs_path_table #(
  parameter int unsigned DEPTH  = 4096,
  parameter int unsigned ADDR_W = 12
) (
  // clock
  input  wire logic              mclk,
  // access port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              wrEn,
  input  wire logic              wrBit,
  output logic                   rdBit
);

  logic store [DEPTH];

  always_ff @(posedge mclk) begin
    if (wrEn) begin
      store[addr] <= wrBit;
    end
  end

  always_ff @(posedge mclk) begin
    rdBit <= store[addr];
  end

endmodule : ccs_path_table

/* src/ccs_control_state.sv */
// Purpose: control-state decoder for pointer, path table, page load and reset
// Assumes: pins are asynchronous to mclk; one control state per chip-enable low
// Notes:   a cycle is taken on the synchronised falling edge of enableN
//
// Notes on behaviour
// - write op 100100 adds one to the address pointer.
// - write op 100101 subtracts one from the address pointer.
// - write op 101000 marks path bit at pointer valid, low.
// - read op 101000 returns path bit on data bit 0, upper bits zero.
// - write op 101001 marks path bit at pointer invalid, high.
// - write op 111100 loads page field from data 3:0, drops full flag.
// - write op 111101 raises full flag again after sequential page loading.
// - write op 111111 is a software reset; page and address outputs all ones.
// - both resets clear pointer; only software reset pulses the array-empty and neighbour clear; instruction clears on hardware only.
// - both resets load status reset image and disable select; hardware sets select value ones.
// - hardware reset loads configuration defaults; software reset keeps them.
// - configuration 31:29 selects direct-write mask register, zero meaning none.
// - configuration 27:26 selects mode; software mode reads status on address-valid high.
// - configuration bit 25 low marks the lowest-priority device.
// - configuration bit 24 low enables path-table comparison.
// - path mask 23:12, path page 11:8, page 3:0; 28 and 7:4 reserved.
module ccs_control_state
  import ccs_pkg::*;
(
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // host cycle pins
  input  wire logic                      enableN,
  input  wire logic                      writeN,
  input  wire logic                      addressValidSelectN,
  input  wire logic [ccs_pkg::OP_W-1:0]  opCode,
  // data bus, split into three signals
  input  wire logic [ccs_pkg::DATA_W-1:0] dataBusIn,
  output logic      [ccs_pkg::DATA_W-1:0] dataBusOut,
  output logic                           dataBusOeN,
  // cascade
  input  wire logic                      upstreamFullN,
  output logic                           fullFlagN,
  // page and address outputs
  output logic      [ccs_pkg::PAGE_W-1:0] pageNumber,
  output logic      [ccs_pkg::ADDR_W-1:0] activeAddress,
  // configuration fields towards the array logic
  output logic      [2:0]                directWriteMaskSel,
  output logic      [1:0]                controlMode,
  output logic                           lowestPriorityDevice,
  output logic                           pathTableDisable,
  output logic      [ccs_pkg::ADDR_W-1:0] pathTableAddrMask,
  output logic      [ccs_pkg::PAGE_W-1:0] pathTablePage,
  // device select
  output logic                           selectEnableN,
  output logic      [ccs_pkg::PAGE_W-1:0] deviceSelectValue,
  // pointer and neighbour clears
  output logic      [ccs_pkg::ADDR_W-1:0] addressPointer,
  output logic                           stateClearPulse
);

  import ccs_pkg::*;

  // ==========
  // pin synchronisers
  logic                enableNS;
  logic                writeNS;
  logic                avNS;
  logic                upFullNS;
  logic [OP_W-1:0]     opS;
  logic [DATA_W-1:0]   dataS;
  logic                enableNPrev_q;

  ccs_sync2 #(.WIDTH(4), .RESET_VAL(4'hF)) uSyncCtl (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn ({enableN, writeN, addressValidSelectN, upstreamFullN}),
    .syncOut ({enableNS, writeNS, avNS, upFullNS})
  );

  // data and op code settle well before enable falls, so a plain bus sync is safe
  ccs_sync2 #(.WIDTH(OP_W + DATA_W), .RESET_VAL('0)) uSyncBus (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn ({opCode, dataBusIn}),
    .syncOut ({opS, dataS})
  );

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      enableNPrev_q <= 1'b1;
    end else begin
      enableNPrev_q <= enableNS;
    end
  end

  // ==========
  // cycle decode
  logic       cycleStart;
  logic       ctlWrite;
  logic       ctlRead;
  logic [5:0] opLo;
  logic       fullFlagN_q;

  assign cycleStart = enableNPrev_q & ~enableNS;
  assign ctlWrite   = cycleStart & ~writeNS & avNS;
  assign ctlRead    = cycleStart & writeNS;
  assign opLo       = opS[OPLO_W-1:0];

  // operands passed in, so the continuous assigns below see every change
  function automatic logic isWriteOp(input logic wr, input logic [5:0] lo, input logic [5:0] code);
    return wr && (lo == code);
  endfunction : isWriteOp

  logic doStepUp;
  logic doStepDown;
  logic doPathValid;
  logic doPathInvalid;
  logic doPageLoad;
  logic doFullClear;
  logic doSoftReset;
  logic doCfgWrite;
  logic doSelWrite;
  logic pageLoadEligible;

  assign doStepUp      = isWriteOp(ctlWrite, opLo, OP_POINTER_STEP_UP);
  assign doStepDown    = isWriteOp(ctlWrite, opLo, OP_POINTER_STEP_DOWN);
  assign doPathValid   = isWriteOp(ctlWrite, opLo, OP_PATH_BIT_SET_VALID);
  assign doPathInvalid = isWriteOp(ctlWrite, opLo, OP_PATH_BIT_SET_INVAL);
  assign doFullClear   = isWriteOp(ctlWrite, opLo, OP_FULL_FLAG_CLEAR);
  assign doSoftReset   = isWriteOp(ctlWrite, opLo, OP_SOFT_RESET);
  assign doCfgWrite    = isWriteOp(ctlWrite, opLo, OP_CONFIG_ACCESS);
  assign doSelWrite    = isWriteOp(ctlWrite, opLo, OP_SELECT_ACCESS);
  // only the first device down the chain that is still empty takes the page
  assign pageLoadEligible = ~upFullNS & fullFlagN_q;
  assign doPageLoad    = isWriteOp(ctlWrite, opLo, OP_PAGE_NUMBER_LOAD) & pageLoadEligible;

  // ==========
  // address pointer
  logic [ADDR_W-1:0] addrPtr_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addrPtr_q <= ADDR_PTR_RESET;
    end else if (doSoftReset) begin
      addrPtr_q <= ADDR_PTR_RESET;
    end else if (doStepUp) begin
      addrPtr_q <= addrPtr_q + 12'h001;
    end else if (doStepDown) begin
      addrPtr_q <= addrPtr_q - 12'h001;
    end
  end

  assign addressPointer = addrPtr_q;

  // ==========
  // path table
  logic pathRdBit;

  ccs_path_table #(.DEPTH(4096), .ADDR_W(ADDR_W)) uPathTable (
    .mclk  (mclk),
    .addr  (addrPtr_q),
    .wrEn  (doPathValid | doPathInvalid),
    .wrBit (doPathInvalid),
    .rdBit (pathRdBit)
  );

  // ==========
  // configuration register
  logic [31:0] cfg_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_q <= CFG_RESET;
    end else if (doCfgWrite) begin
      cfg_q <= dataS & CFG_WR_MASK;
    end else if (doPageLoad) begin
      cfg_q[CFG_PAGE_LO +: PAGE_W] <= dataS[PAGE_W-1:0];
    end
    // software reset leaves every configuration field alone
  end

  assign directWriteMaskSel   = cfg_q[CFG_MASKSRC_LO +: 3];
  assign controlMode          = cfg_q[CFG_MODE_LO +: 2];
  assign lowestPriorityDevice = cfg_q[CFG_LOWPRI_BIT];
  assign pathTableDisable     = cfg_q[CFG_PTDIS_BIT];
  assign pathTableAddrMask    = cfg_q[CFG_PTMASK_LO +: ADDR_W];
  assign pathTablePage        = cfg_q[CFG_PTPAGE_LO +: PAGE_W];

  // ==========
  // device select register
  logic [31:0] sel_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sel_q <= SEL_RESET;
    end else if (doSoftReset) begin
      sel_q[SEL_ENABLE_BIT] <= 1'b1;
    end else if (doSelWrite) begin
      sel_q <= dataS & SEL_WR_MASK;
    end
  end

  assign selectEnableN     = sel_q[SEL_ENABLE_BIT];
  assign deviceSelectValue = sel_q[SEL_VALUE_LO +: PAGE_W];

  // ==========
  // full flag

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fullFlagN_q <= 1'b1;
    end else if (doSoftReset || doFullClear) begin
      fullFlagN_q <= 1'b1;
    end else if (doPageLoad) begin
      fullFlagN_q <= 1'b0;
    end
  end

  assign fullFlagN = fullFlagN_q;

  // ==========
  // instruction register, cleared by hardware reset only
  logic [OP_W-1:0] instr_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      instr_q <= INSTR_RESET;
    end else if (ctlWrite && !doSoftReset) begin
      instr_q <= opS;
    end
  end

  // ==========
  // page and address outputs, active address type
  logic [PAGE_W-1:0] pageOut_q;
  logic [ADDR_W-1:0] addrOut_q;
  ccs_atype_e        atype_q;
  logic              pathCycle;

  assign pathCycle = cycleStart & avNS &
                     ((opLo == OP_PATH_BIT_SET_VALID) | (opLo == OP_PATH_BIT_SET_INVAL));

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pageOut_q <= PAGE_ALL_ONES;
      addrOut_q <= ADDR_ALL_ONES;
      atype_q   <= ATYPE_RESET;
    end else if (doSoftReset) begin
      pageOut_q <= PAGE_ALL_ONES;
      addrOut_q <= ADDR_ALL_ONES;
      atype_q   <= ATYPE_RESET;
    end else if (pathCycle) begin
      pageOut_q <= cfg_q[CFG_PAGE_LO +: PAGE_W];
      addrOut_q <= addrPtr_q;
      atype_q   <= ATYPE_PATH;
    end
  end

  assign pageNumber    = pageOut_q;
  assign activeAddress = addrOut_q;

  // ==========
  // status image; match flags stay at their reset value in this block
  logic [31:0] statusWord;

  always_comb begin
    statusWord = '0;
    statusWord[STAT_FULL_BIT +: 4]     = {STAT_MATCH_RST, fullFlagN_q};
    statusWord[STAT_ATYPE_LO +: 2]     = atype_q;
    statusWord[STAT_PAGE_LO +: PAGE_W] = pageOut_q;
    statusWord[ADDR_W-1:0]             = addrOut_q;
  end

  // ==========
  // neighbour clear: array empty, comparand, masks, next-free
  logic clearPulse_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clearPulse_q <= 1'b0;
    end else begin
      clearPulse_q <= doSoftReset;
    end
  end

  assign stateClearPulse = clearPulse_q;

  // ==========
  // read path
  logic [DATA_W-1:0] rdData_q;
  logic              driving_q;
  logic              pathReadPend_q;
  logic [DATA_W-1:0] rdSel;

  // path bit is registered in the table, so its read lands one cycle later
  always_comb begin
    rdSel = '0;
    if (!avNS) begin
      rdSel = '0;
    end else if (opLo == OP_CONFIG_ACCESS) begin
      rdSel = cfg_q;
    end else if (opLo == OP_SELECT_ACCESS) begin
      rdSel = sel_q;
    end else if (opLo == OP_INSTR_READ) begin
      rdSel = {{(DATA_W-OP_W){1'b0}}, instr_q};
    end else if (controlMode == MODE_SOFTWARE) begin
      rdSel = statusWord;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pathReadPend_q <= 1'b0;
    end else begin
      pathReadPend_q <= ctlRead & avNS & (opLo == OP_PATH_BIT_READ);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdData_q <= '0;
    end else if (pathReadPend_q) begin
      rdData_q <= {{(DATA_W-1){1'b0}}, pathRdBit};
    end else if (ctlRead && !(avNS && opLo == OP_PATH_BIT_READ)) begin
      rdData_q <= rdSel;
    end
  end

  // bus released as soon as enable or read is withdrawn
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      driving_q <= 1'b0;
    end else if (enableNS || !writeNS) begin
      driving_q <= 1'b0;
    end else if (ctlRead) begin
      driving_q <= 1'b1;
    end
  end

  assign dataBusOut = rdData_q;
  assign dataBusOeN = ~(driving_q & ~pathReadPend_q);

endmodule : ccs_control_state

/* verification/ccs_control_state_properties.sv */
// Purpose: port-level checks for the control-state decoder
// Assumes: one control state per enable-low period
// Notes:   own copy of the pin sync, so effects get a short window
module ccs_control_state_properties
  import ccs_pkg::*;
(
  // clock and reset
  input wire logic                       mclk,
  input wire logic                       reset,
  // host pins
  input wire logic                       enableN,
  input wire logic                       writeN,
  input wire logic                       addressValidSelectN,
  input wire logic [ccs_pkg::OP_W-1:0]   opCode,
  input wire logic                       upstreamFullN,
  // device outputs
  input wire logic [ccs_pkg::DATA_W-1:0] dataBusOut,
  input wire logic                       dataBusOeN,
  input wire logic                       fullFlagN,
  input wire logic [ccs_pkg::PAGE_W-1:0] pageNumber,
  input wire logic [ccs_pkg::ADDR_W-1:0] activeAddress,
  input wire logic [1:0]                 controlMode,
  input wire logic [ccs_pkg::ADDR_W-1:0] pathTableAddrMask,
  input wire logic                       selectEnableN,
  input wire logic [ccs_pkg::ADDR_W-1:0] addressPointer,
  input wire logic                       stateClearPulse
);
  import ccs_pkg::*;

  // ==========
  // take detect
  logic [2:0]        enSync_q;
  logic [ADDR_W-1:0] ptrSnap_q;
  logic [5:0]        opSnap_q;
  logic              take;
  logic              wrCs;
  logic [5:0]        op;

  assign take = enSync_q[2] & ~enSync_q[1];
  assign wrCs = take & ~writeN & addressValidSelectN;
  assign op   = opCode[5:0];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      enSync_q <= 3'h7;
    end else begin
      enSync_q <= {enSync_q[1:0], enableN};
    end
  end

  // snapshot holds the pre-update pointer, taken before the effect lands
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ptrSnap_q <= 12'h000;
      opSnap_q  <= 6'h00;
    end else if (take) begin
      ptrSnap_q <= addressPointer;
      opSnap_q  <= op;
    end
  end

  // ==========
  // assertions
  a_step_up: assert property (@(posedge mclk) disable iff (reset)
    wrCs && op == OP_POINTER_STEP_UP |-> ##[1:3] addressPointer == ptrSnap_q + 12'h001)
    else $error("pointer did not step up");
  a_step_down: assert property (@(posedge mclk) disable iff (reset)
    wrCs && op == OP_POINTER_STEP_DOWN |-> ##[1:3] addressPointer == ptrSnap_q - 12'h001)
    else $error("pointer did not step down");
  a_page_load_full: assert property (@(posedge mclk) disable iff (reset)
    wrCs && op == OP_PAGE_NUMBER_LOAD && !upstreamFullN && fullFlagN |-> ##[1:3] !fullFlagN)
    else $error("page load did not set full");
  a_page_load_refused: assert property (@(posedge mclk) disable iff (reset)
    wrCs && op == OP_PAGE_NUMBER_LOAD && upstreamFullN && fullFlagN |=> fullFlagN [*3])
    else $error("ineligible page load set full");
  a_full_clear: assert property (@(posedge mclk) disable iff (reset)
    wrCs && op == OP_FULL_FLAG_CLEAR |-> ##[1:3] fullFlagN)
    else $error("full flag not cleared");
  a_soft_reset_out: assert property (@(posedge mclk) disable iff (reset)
    wrCs && op == OP_SOFT_RESET |-> ##[1:3] pageNumber == 4'hF && activeAddress == 12'hFFF
      && addressPointer == 12'h000 && selectEnableN && fullFlagN)
    else $error("soft reset outputs wrong");
  a_clear_pulse: assert property (@(posedge mclk) disable iff (reset)
    wrCs && op == OP_SOFT_RESET |-> ##[1:4] stateClearPulse ##1 !stateClearPulse)
    else $error("clear pulse missing or long");
  a_path_read_upper: assert property (@(posedge mclk) disable iff (reset)
    !dataBusOeN && opSnap_q == OP_PATH_BIT_READ |-> dataBusOut[31:1] == 31'h0000_0000)
    else $error("path read upper bits not zero");
  a_hw_reset_vals: assert property (@(posedge mclk) disable iff (reset)
    $fell(reset) |-> controlMode == 2'h3 && pathTableAddrMask == 12'hFFF && pageNumber == 4'hF
      && fullFlagN && dataBusOeN)
    else $error("hardware reset values wrong");

endmodule : ccs_control_state_properties

bind ccs_control_state ccs_control_state_properties chk_u (
  .mclk(mclk), .reset(reset), .enableN(enableN), .writeN(writeN),
  .addressValidSelectN(addressValidSelectN), .opCode(opCode), .upstreamFullN(upstreamFullN),
  .dataBusOut(dataBusOut), .dataBusOeN(dataBusOeN), .fullFlagN(fullFlagN), .pageNumber(pageNumber),
  .activeAddress(activeAddress), .controlMode(controlMode), .pathTableAddrMask(pathTableAddrMask),
  .selectEnableN(selectEnableN), .addressPointer(addressPointer), .stateClearPulse(stateClearPulse)
);

/* verification/ccs_host_model.sv */
// Purpose: host controller issuing control states on the pins
// Assumes: address-valid select held high for every control state
// Notes:   released data lines show the inverse of the last value
module ccs_host_model
  import ccs_pkg::*;
(
  // clock
  input wire logic                       mclk,
  // device read side
  input wire logic [ccs_pkg::DATA_W-1:0] dataBusOut,
  input wire logic                       dataBusOeN,
  // pins towards the device
  output logic                           enableN,
  output logic                           writeN,
  output logic                           addressValidSelectN,
  output logic     [ccs_pkg::OP_W-1:0]   opCode,
  output logic     [ccs_pkg::DATA_W-1:0] dataBusIn
);
  import ccs_pkg::*;

  initial begin
    enableN             = 1'b1;
    writeN              = 1'b1;
    addressValidSelectN = 1'b1;
    opCode              = 12'h000;
    dataBusIn           = 32'h0000_0000;
  end

  // lowLen sets a prompt or slow cycle; op and data settle before enable falls
  task automatic cycle(input logic wr, input logic [11:0] op, input logic [31:0] d,
                       input int lowLen, output logic [31:0] rd, output logic oeN);
    @(posedge mclk);
    writeN              <= ~wr;
    opCode              <= op;
    dataBusIn           <= d;
    addressValidSelectN <= 1'b1;
    repeat (3) @(posedge mclk);
    enableN <= 1'b0;
    repeat (lowLen) @(posedge mclk);
    rd = dataBusOut;
    oeN = dataBusOeN;
    enableN   <= 1'b1;
    dataBusIn <= ~d;
    repeat (4) @(posedge mclk);
  endtask : cycle

endmodule : ccs_host_model

/* verification/testbench.sv */
// Purpose: self-checking bench for the control-state decoder
// Assumes: host model drives all cycle pins
// Notes:   random values from a fixed seed, corner cases forced
`define CHK(act, exp) \
  begin checkCount++; if ((act) !== (exp)) begin failCount++; \
  $display("[ERR] %0t got %h want %h", $time, (act), (exp)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ccs_pkg::*;

  logic              mclk = 1'b0;
  logic              reset, upstreamFullN, enableN, writeN, addressValidSelectN, dataBusOeN, fullFlagN;
  logic              lowestPriorityDevice, pathTableDisable, selectEnableN, stateClearPulse, oeN, b, bit0;
  logic [OP_W-1:0]   opCode;
  logic [DATA_W-1:0] dataBusIn, dataBusOut, rd, v, cfgSaved;
  logic [PAGE_W-1:0] pageNumber, pathTablePage, deviceSelectValue, pg, selVal;
  logic [ADDR_W-1:0] activeAddress, pathTableAddrMask, addressPointer, ptr;
  logic [2:0]        directWriteMaskSel;
  logic [1:0]        controlMode;
  logic [22:0]       cfgOut;
  int                seed = 32'hfddf03b2;
  int                failCount = 0, checkCount = 0, cycleCount = 0, pulseCount = 0;

  assign cfgOut = {directWriteMaskSel, controlMode, lowestPriorityDevice, pathTableDisable,
                   pathTableAddrMask, pathTablePage};

  always #2 mclk = ~mclk;

  ccs_host_model host_u (.mclk(mclk), .dataBusOut(dataBusOut), .dataBusOeN(dataBusOeN), .enableN(enableN),
    .writeN(writeN), .addressValidSelectN(addressValidSelectN), .opCode(opCode), .dataBusIn(dataBusIn));

  ccs_control_state dut_u (.mclk(mclk), .reset(reset), .enableN(enableN), .writeN(writeN),
    .addressValidSelectN(addressValidSelectN), .opCode(opCode), .dataBusIn(dataBusIn),
    .dataBusOut(dataBusOut), .dataBusOeN(dataBusOeN), .upstreamFullN(upstreamFullN), .fullFlagN(fullFlagN),
    .pageNumber(pageNumber), .activeAddress(activeAddress), .directWriteMaskSel(directWriteMaskSel),
    .controlMode(controlMode), .lowestPriorityDevice(lowestPriorityDevice), .pathTableDisable(pathTableDisable),
    .pathTableAddrMask(pathTableAddrMask), .pathTablePage(pathTablePage), .selectEnableN(selectEnableN),
    .deviceSelectValue(deviceSelectValue), .addressPointer(addressPointer), .stateClearPulse(stateClearPulse));

  function automatic logic [22:0] cfgFields(input logic [31:0] c);
    return {c[31:29], c[27:8]};
  endfunction : cfgFields

  // upper op bits are don't-care, so they are randomised
  task automatic cs(input logic wr, input logic [5:0] op, input logic [31:0] d);
    host_u.cycle(wr, {6'($random(seed)), op}, d, 7 + ($random(seed) & 3), rd, oeN);
  endtask : cs

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tallyAndFinish

  always @(posedge mclk) begin
    cycleCount++;
    pulseCount += int'(stateClearPulse === 1'b1);
    if (cycleCount == 6000) begin
      failCount++;
      $display("[ERR] %0t run took too long", $time);
      tallyAndFinish();
    end
  end

  initial begin
    reset = 1'b1;
    upstreamFullN = 1'b0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    `CHK({pageNumber, activeAddress, fullFlagN, addressPointer, selectEnableN, deviceSelectValue},
         {4'hF, 12'hFFF, 1'b1, 12'h000, 1'b1, 4'hF})
    `CHK(cfgOut, cfgFields(CFG_RESET))
    cs(0, OP_SELECT_ACCESS, 32'h0000_0000);
    `CHK(rd, SEL_RESET)
    $display("test reset values done");
    // ==========
    // configuration fields: corners, then random in both legal modes
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'hFFFF_FFFF : $random(seed);
      v = (i == 2) ? (v | 32'h0C00_0000) : (i == 3) ? (v & 32'hF3FF_FFFF) : v;
      cs(1, OP_CONFIG_ACCESS, v);
      `CHK(cfgOut, cfgFields(v & CFG_WR_MASK))
      cs(0, OP_CONFIG_ACCESS, 32'h0000_0000);
      `CHK({rd, oeN}, {v & CFG_WR_MASK, 1'b0})
    end
    cfgSaved = v & CFG_WR_MASK;
    $display("test configuration done");
    // ==========
    // pointer: wrap down from zero, wrap back up, then random steps
    ptr = 12'h000;
    for (int i = 0; i < 10; i++) begin
      b = (i == 0) ? 1'b0 : (i == 1) ? 1'b1 : 1'($random(seed));
      cs(1, b ? OP_POINTER_STEP_UP : OP_POINTER_STEP_DOWN, $random(seed));
      ptr = b ? ptr + 12'h001 : ptr - 12'h001;
      `CHK(addressPointer, ptr)
    end
    $display("test pointer done");
    // ==========
    // page load: refused upstream, taken, refused when own full, cleared
    @(posedge mclk) upstreamFullN <= 1'b1;
    cs(1, OP_PAGE_NUMBER_LOAD, $random(seed));
    `CHK(fullFlagN, 1'b1)
    @(posedge mclk) upstreamFullN <= 1'b0;
    pg = 4'($random(seed));
    cs(1, OP_PAGE_NUMBER_LOAD, {28'h000_0000, pg});
    `CHK(fullFlagN, 1'b0)
    cs(1, OP_PAGE_NUMBER_LOAD, {28'h000_0000, ~pg});
    cs(0, OP_CONFIG_ACCESS, 32'h0000_0000);
    `CHK(rd, {cfgSaved[31:4], pg})
    cs(1, OP_FULL_FLAG_CLEAR, $random(seed));
    `CHK(fullFlagN, 1'b1)
    cfgSaved = {cfgSaved[31:4], pg};
    $display("test page load done");
    // ==========
    // soft reset keeps configuration and select value
    selVal = 4'($random(seed));
    cs(1, OP_SELECT_ACCESS, {28'h000_0000, selVal});
    cs(1, OP_SOFT_RESET, $random(seed));
    `CHK({pageNumber, activeAddress, addressPointer, fullFlagN, selectEnableN, deviceSelectValue},
         {4'hF, 12'hFFF, 12'h000, 1'b1, 1'b1, selVal})
    `CHK(pulseCount, 1)
    cs(0, OP_CONFIG_ACCESS, 32'h0000_0000);
    `CHK(rd, cfgSaved)
    $display("test soft reset done");
    // ==========
    // path bits at pointer 0 upward, read straight back
    for (int i = 0; i < 4; i++) begin
      b = 1'($random(seed));
      bit0 = (i == 0) ? b : bit0;
      cs(1, b ? OP_PATH_BIT_SET_INVAL : OP_PATH_BIT_SET_VALID, $random(seed));
      cs(0, OP_PATH_BIT_READ, $random(seed));
      `CHK({rd, oeN, pageNumber, activeAddress}, {31'h0000_0000, b, 1'b0, cfgSaved[3:0], 12'(i)})
      cs(1, OP_POINTER_STEP_UP, $random(seed));
    end
    cs(1, OP_SOFT_RESET, $random(seed));
    cs(0, OP_PATH_BIT_READ, $random(seed));
    `CHK(rd, {31'h0000_0000, bit0})
    $display("test path table done");
    // ==========
    // hardware reset mid-run: defaults back, path table untouched
    @(posedge mclk) reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    `CHK({cfgOut, deviceSelectValue, addressPointer}, {cfgFields(CFG_RESET), 4'hF, 12'h000})
    // read of an unclaimed code returns status in software mode
    cs(0, OP_SOFT_RESET, $random(seed));
    `CHK(rd, STAT_RESET)
    cs(0, OP_INSTR_READ, $random(seed));
    `CHK(rd, 32'(INSTR_RESET))
    cs(0, OP_PATH_BIT_READ, $random(seed));
    `CHK(rd, {31'h0000_0000, bit0})
    $display("test hardware reset done");
    tallyAndFinish();
  end

endmodule : testbench
